// File: sec_prescaler.sv
// one-cycle tick once per second
`timescale 1ns/1ns
`default_nettype none
`include "touch_sleep_defs.svh"
module sec_prescaler #(
  parameter int unsigned CYC = `CLK_HZ
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  import touch_sleep_pkg::*;
  presc_state_type s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= CYC - 1)
    begin
      s_nxt.cnt = 32'h00000000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = s_r.cnt + 32'h00000001;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_o = s_r.tick;
endmodule // sec_prescaler
`default_nettype wire

// File: sleep_timer.sv
// counts ticks up to a limit; expired holds until cleared
`timescale 1ns/1ns
`default_nettype none
module sleep_timer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  timer_if.tmr t
);
  import touch_sleep_pkg::*;
  timer_state_type s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (t.clear)
    begin
      s_nxt.cnt = 16'h0000;
      s_nxt.expired = 1'b0;
    end
    else if (t.tick && !s_r.expired)
    begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
      s_nxt.expired = (s_r.cnt + 16'h0001) >= t.limit;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign t.expired = s_r.expired;
endmodule // sleep_timer
`default_nettype wire

// File: testbench.sv
// self-checking bench of the sleep and wake controller
`timescale 1ns/1ns
`default_nettype none
`include "touch_sleep_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] key_touch = 16'h0000;
  logic [15:0] baseline = 16'h0000;
  logic prox = 1'b0;
  logic host = 1'b0;
  logic [3:0] key_sel = 4'h0;
  logic [15:0] key_val = 16'h0000;
  logic res_valid, scan_done, scan_start, asleep, adj, irq, irq_n;
  logic [3:0] res_key;
  logic [15:0] res_value, rdata, rv;
  logic [7:0] ra [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h09, 8'h20};
  logic [15:0] re [9] = '{16'h0000, `RST_SLEEP_TIME, `RST_WAKE_THR,
    `RST_BASE_MAVG, `RST_START_DLY, `RST_PERIOD, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0] wk [3] = '{4'h5, 4'h4, 4'h4};
  logic [15:0] wv [3] = '{16'h0064, 16'h0007, 16'h0008};
  logic ws [3] = '{1'b1, 1'b1, 1'b0};
  int error_cnt = 0;
  int checks = 0;
  int n;
  always #10 clock_i = ~clock_i;
  touch_sleep_wake_control #(.SEC_CYCLES(16)) dut_u (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .key_touch_i(key_touch), .res_valid_i(res_valid),
    .res_key_i(res_key), .res_value_i(res_value), .scan_done_i(scan_done),
    .baseline_i(baseline), .prox_detect_i(prox), .host_connect_i(host),
    .scan_start_o(scan_start), .asleep_o(asleep), .baseline_adj_o(adj),
    .irq_o(irq), .irq_out_n_o(irq_n));
  touch_scan_model model_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .scan_start_i(scan_start), .key_sel_i(key_sel), .value_i(key_val),
    .res_valid_o(res_valid), .res_key_o(res_key), .res_value_o(res_value),
    .scan_done_o(scan_done));
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    rv = rdata;
    `CHK(rv, e)
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_sleep(input logic v, input int lim);
    n = 0;
    while (asleep !== v && n < lim)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK(asleep, v)
  endtask
  task automatic wake_host;
    @(posedge clock_i);
    host <= 1'b1;
    @(posedge clock_i);
    host <= 1'b0;
    wait_sleep(1'b0, 4);
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    while (n < lim)
    begin
      @(posedge clock_i);
      n = (scan_done === 1'b1) ? lim : n + 1;
    end
  endtask
  // cycles from end of one sequence to start of the next
  task automatic meas(input int e);
    wait_done(3000);
    n = 0;
    do
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    while (scan_start !== 1'b1 && n < 3000);
    `CHK(n >= e && n <= e + 2, 1'b1)
  endtask
  task automatic conclude;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1200000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd_chk(ra[i], re[i]);
    wr_reg(`ADDR_STATE, 16'h0001);
    rd_chk(`ADDR_STATE, 16'h0000);
    meas(512);
    wr_reg(`ADDR_START_DLY, 16'h0000);
    meas(256);
    meas(256);
    wr_reg(`ADDR_CTRL, 16'h0008);
    wait_sleep(1'b1, 5);
    rd_chk(`ADDR_STATE, 16'h0001);
    rd_chk(`ADDR_INT_STAT, 16'h0002);
    `CHK(irq, 1'b0)
    wr_reg(`ADDR_INT_MASK, 16'h0007);
    cycles(2);
    `CHK(irq, 1'b1)
    wr_reg(`ADDR_INT_STAT, 16'h0002);
    cycles(2);
    `CHK(irq, 1'b0)
    wake_host();
    `CHK(irq_n, 1'b1)
    rd_chk(`ADDR_INT_STAT, 16'h0001);
    wr_reg(`ADDR_INT_STAT, 16'h0001);
    wr_reg(`ADDR_CTRL, 16'h000C);
    wait_sleep(1'b1, 5);
    `CHK(irq_n, 1'b1)
    wake_host();
    cycles(2);
    `CHK(irq_n, 1'b0)
    rd_chk(`ADDR_KEY_STAT_LO, 16'h0000);
    rd_chk(`ADDR_KEY_STAT_HI, 16'h0000);
    cycles(2);
    `CHK(irq_n, 1'b1)
    wr_reg(`ADDR_INT_STAT, 16'h0007);
    wr_reg(`ADDR_KEY_EN, 16'h0030);
    wr_reg(`ADDR_WAKE_EN, 16'h0010);
    wr_reg(`ADDR_PERIOD, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_i);
      key_sel <= wk[i];
      key_val <= wv[i];
      wr_reg(`ADDR_CTRL, 16'h0008);
      wait_sleep(1'b1, 5);
      wait_done(3000);
      wait_done(3000);
      cycles(3);
      `CHK(asleep, ws[i])
    end
    wr_reg(`ADDR_PERIOD, 16'h0002);
    wr_reg(`ADDR_SLEEP_TIME, 16'h0002);
    key_touch <= 16'h0010;
    wr_reg(`ADDR_CTRL, 16'h0001);
    cycles(100);
    `CHK(asleep, 1'b0)
    @(posedge clock_i);
    key_touch <= 16'h0000;
    cycles(8);
    `CHK(asleep, 1'b0)
    wait_sleep(1'b1, 60);
    wake_host();
    wr_reg(`ADDR_SLEEP_TIME, 16'h00FF);
    baseline <= 16'h0020;
    cycles(10);
    `CHK(asleep, 1'b0)
    @(posedge clock_i);
    baseline <= 16'h0021;
    wait_sleep(1'b1, 5);
    @(posedge clock_i);
    baseline <= 16'h0000;
    wake_host();
    wr_reg(`ADDR_CTRL, 16'h000A);
    wait_sleep(1'b1, 5);
    @(posedge clock_i);
    prox <= 1'b1;
    wait_sleep(1'b0, 4);
    @(posedge clock_i);
    prox <= 1'b0;
    cycles(100);
    `CHK(asleep, 1'b0)
    n = 0;
    while (adj !== 1'b1 && n < 100)
    begin
      cycles(1);
      n++;
    end
    n = 0;
    do
    begin
      cycles(1);
      n++;
    end
    while (adj !== 1'b1 && n < 100);
    `CHK(n >= 32 && n <= 48, 1'b1)
    conclude();
  end
endmodule // testbench
`default_nettype wire

// File: timer_if.sv
// control and status of one seconds timer
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
  logic clear;
  logic tick;
  logic [15:0] limit;
  logic expired;
  modport ctrl (output clear, output tick, output limit, input expired);
  modport tmr (input clear, input tick, input limit, output expired);
endinterface
`default_nettype wire

// File: touch_scan_model.sv
// scan engine stand-in: answers each sequence start with one result
`timescale 1ns/1ns
`default_nettype none
module touch_scan_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scan_start_i,
  input wire logic [3:0] key_sel_i,
  input wire logic [15:0] value_i,
  output logic res_valid_o,
  output logic [3:0] res_key_o,
  output logic [15:0] res_value_o,
  output logic scan_done_o
);
  logic [2:0] step_r;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step_r <= 3'h0;
      res_valid_o <= 1'b0;
      res_key_o <= 4'h0;
      res_value_o <= 16'h0000;
      scan_done_o <= 1'b0;
    end
    else
    begin
      if (scan_start_i)
        step_r <= 3'h1;
      else if (step_r != 3'h0)
        step_r <= step_r + 3'h1;
      res_valid_o <= (step_r == 3'h2);
      // result lines toggle outside the valid cycle so stale data is seen
      res_key_o <= (step_r == 3'h2) ? key_sel_i : ~res_key_o;
      res_value_o <= (step_r == 3'h2) ? value_i : ~res_value_o;
      scan_done_o <= (step_r == 3'h4);
    end
  end
endmodule // touch_scan_model
`default_nettype wire

// File: touch_sleep_defs.svh
// register map, field positions, reset values and timing counts
`ifndef TOUCH_SLEEP_DEFS_SVH
`define TOUCH_SLEEP_DEFS_SVH

`define ADDR_CTRL 8'h00
`define ADDR_SLEEP_TIME 8'h01
`define ADDR_WAKE_THR 8'h02
`define ADDR_BASE_MAVG 8'h03
`define ADDR_START_DLY 8'h04
`define ADDR_PERIOD 8'h05
`define ADDR_KEY_EN 8'h06
`define ADDR_WAKE_EN 8'h07
`define ADDR_STATE 8'h08
`define ADDR_INT_STAT 8'h09
`define ADDR_INT_MASK 8'h0A
`define ADDR_KEY_STAT_LO 8'h0B
`define ADDR_KEY_STAT_HI 8'h0C

`define CTRL_AUTO_EN 0
`define CTRL_PROX_EN 1
`define CTRL_GIE 2
`define CTRL_FORCE 3

`define INT_WAKE 0
`define INT_SLEEP 1
`define INT_TOUCH 2

`define RST_SLEEP_TIME 8'h0B
`define RST_WAKE_THR 16'h0008
`define RST_BASE_MAVG 16'h0020
`define RST_START_DLY 8'h01
`define RST_PERIOD 8'h02

`define CLK_HZ 50000000
`define SEC_TIME_S 1
`define SEC_CYCLES (`CLK_HZ * `SEC_TIME_S)
`define START_DLY_UNIT 17'h00100

`endif

// File: touch_sleep_pkg.sv
// state types of the sleep and wake controller
`default_nettype none
package touch_sleep_pkg;
  typedef enum logic [2:0] {
    ST_DELAY, ST_SCAN, ST_SLEEP, ST_WDELAY, ST_WSCAN
  } mode_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } presc_state_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic expired;
  } timer_state_type;

  typedef struct packed {
    mode_type st;
    logic [16:0] dly_cnt;
    logic hit;
    logic auto_en;
    logic prox_en;
    logic gie;
    logic force_sl;
    logic [7:0] sleep_time;
    logic [15:0] wake_thr;
    logic [15:0] mavg;
    logic [7:0] start_dly;
    logic [7:0] period;
    logic [15:0] key_en;
    logic [15:0] wake_en;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic rd_lo;
    logic rd_hi;
    logic wake_pend;
    logic touch_prev;
    logic [15:0] rdata;
    logic irq;
    logic irq_n;
    logic asleep;
    logic scan_start;
    logic base_adj;
  } main_state_type;
endpackage
`default_nettype wire

// File: touch_sleep_wake_control.sv
// sleep and wake controller of the touch-key scanner
//
// Function
// - auto sleep after idle time when enabled
// - key wake only from touch key with wake enable
// - wake when wake key value reaches threshold
// - no proximity: one wake scan, then sleep
// - proximity wakes; sleep again after idle time
// - wake drives irq_out_n_o only with global enable; irq_o by int_mask alone
// - with auto sleep enabled, sleep when baseline exceeds moving-average setting
// - idle (delay+1)*256 scan clocks before sequence
// - baseline adjust each period, default two seconds
// - forced sleep command sleeps at once
// - wake on wake key or host reconnect
// - stay awake while wake key held, except on a forced sleep command
// - interrupt low on touch, released on reads
`timescale 1ns/1ns
`default_nettype none
`include "touch_sleep_defs.svh"
module touch_sleep_wake_control #(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] key_touch_i,
  input wire logic res_valid_i,
  input wire logic [3:0] res_key_i,
  input wire logic [15:0] res_value_i,
  input wire logic scan_done_i,
  input wire logic [15:0] baseline_i,
  input wire logic prox_detect_i,
  input wire logic host_connect_i,
  output logic scan_start_o,
  output logic asleep_o,
  output logic baseline_adj_o,
  output logic irq_o,
  output logic irq_out_n_o
);
  import touch_sleep_pkg::*;

  main_state_type s_r, s_nxt;
  logic sec_tick;
  logic [16:0] dly_limit;
  logic normal;
  logic touch_seen;
  logic held;
  logic hit_now;
  logic wake;
  logic go_sleep;
  logic both_read;
  logic [2:0] int_set;
  logic [2:0] int_clr;

  timer_if auto_if ();
  timer_if per_if ();

  sec_prescaler #(
    .CYC(SEC_CYCLES)
  ) u_presc (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(sec_tick)
  );

  sleep_timer u_auto (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .t(auto_if.tmr)
  );

  sleep_timer u_period (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .t(per_if.tmr)
  );

  assign normal = (s_r.st == ST_DELAY) || (s_r.st == ST_SCAN);
  assign touch_seen = |(key_touch_i & s_r.key_en);
  assign held = |(key_touch_i & s_r.key_en & s_r.wake_en);
  // per-scan result of one key against the wake threshold
  assign hit_now = res_valid_i && s_r.key_en[res_key_i] &&
                   s_r.wake_en[res_key_i] &&
                   (res_value_i >= s_r.wake_thr);
  assign dly_limit = (({9'h000, s_r.start_dly} + 17'h00001) *
                      `START_DLY_UNIT) - 17'h00001;

  // idle timer, cleared while asleep, while auto sleep is off or while an enabled key is touched
  assign auto_if.tick = sec_tick;
  assign auto_if.limit = {8'h00, s_r.sleep_time};
  assign auto_if.clear = !s_r.auto_en || touch_seen || wake ||
                         !normal;
  // period timer restarts itself on expiry
  assign per_if.tick = sec_tick;
  assign per_if.limit = {8'h00, s_r.period};
  assign per_if.clear = per_if.expired;

  always_comb
  begin
    wake = 1'b0;
    if (!normal)
    begin
      if (host_connect_i)
        wake = 1'b1;
      else if (s_r.prox_en && prox_detect_i)
        wake = 1'b1;
      else if ((s_r.st == ST_WSCAN) && scan_done_i &&
               (s_r.hit || hit_now))
        wake = 1'b1;
    end
  end

  // force wins over a held key; idle and baseline do not
  assign go_sleep = normal && (s_r.force_sl ||
                    (auto_if.expired && !held) ||
                    (s_r.auto_en && (baseline_i > s_r.mavg) &&
                     !held));

  assign both_read = rd_i &&
                     (((addr_i == `ADDR_KEY_STAT_HI) && s_r.rd_lo) ||
                      ((addr_i == `ADDR_KEY_STAT_LO) && s_r.rd_hi));

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.scan_start = 1'b0;
    s_nxt.force_sl = 1'b0;
    s_nxt.base_adj = per_if.expired;
    int_set = 3'h0;
    int_clr = 3'h0;
    unique case (s_r.st)
      ST_DELAY, ST_WDELAY:
      begin
        if (s_r.dly_cnt >= dly_limit)
        begin
          s_nxt.dly_cnt = 17'h00000;
          s_nxt.scan_start = 1'b1;
          s_nxt.hit = 1'b0;
          s_nxt.st = (s_r.st == ST_DELAY) ? ST_SCAN : ST_WSCAN;
        end
        else
          s_nxt.dly_cnt = s_r.dly_cnt + 17'h00001;
      end
      ST_SCAN:
      begin
        if (scan_done_i)
        begin
          s_nxt.st = ST_DELAY;
          s_nxt.dly_cnt = 17'h00000;
        end
      end
      ST_SLEEP:
      begin
        if (per_if.expired)
        begin
          s_nxt.st = ST_WDELAY;
          s_nxt.dly_cnt = 17'h00000;
        end
      end
      ST_WSCAN:
      begin
        if (hit_now)
          s_nxt.hit = 1'b1;
        if (scan_done_i)
          s_nxt.st = ST_SLEEP;
      end
    endcase
    if (wake)
    begin
      s_nxt.st = ST_DELAY;
      s_nxt.dly_cnt = 17'h00000;
      s_nxt.hit = 1'b0;
      // a wake seen with the global enable off never pulls irq_out_n_o later
      s_nxt.wake_pend = s_r.wake_pend || s_r.gie;
      s_nxt.rd_lo = 1'b0;
      s_nxt.rd_hi = 1'b0;
      int_set[`INT_WAKE] = 1'b1;
    end
    else if (go_sleep)
    begin
      s_nxt.st = ST_SLEEP;
      s_nxt.dly_cnt = 17'h00000;
      int_set[`INT_SLEEP] = 1'b1;
    end
    s_nxt.asleep = (s_nxt.st != ST_DELAY) && (s_nxt.st != ST_SCAN);
    s_nxt.touch_prev = touch_seen;
    int_set[`INT_TOUCH] = touch_seen && !s_r.touch_prev;

    if (wr_i)
    begin
      unique case (addr_i)
        `ADDR_CTRL:
        begin
          s_nxt.auto_en = wdata_i[`CTRL_AUTO_EN];
          s_nxt.prox_en = wdata_i[`CTRL_PROX_EN];
          s_nxt.gie = wdata_i[`CTRL_GIE];
          s_nxt.force_sl = wdata_i[`CTRL_FORCE];
        end
        `ADDR_SLEEP_TIME: s_nxt.sleep_time = wdata_i[7:0];
        `ADDR_WAKE_THR: s_nxt.wake_thr = wdata_i;
        `ADDR_BASE_MAVG: s_nxt.mavg = wdata_i;
        `ADDR_START_DLY: s_nxt.start_dly = wdata_i[7:0];
        `ADDR_PERIOD: s_nxt.period = wdata_i[7:0];
        `ADDR_KEY_EN: s_nxt.key_en = wdata_i;
        `ADDR_WAKE_EN: s_nxt.wake_en = wdata_i;
        `ADDR_INT_STAT: int_clr = wdata_i[2:0];
        `ADDR_INT_MASK: s_nxt.int_mask = wdata_i[2:0];
        default: ;
      endcase
    end
    // a new event beats a write-one clear in the same cycle
    s_nxt.int_stat = int_set | (s_r.int_stat & ~int_clr);
    s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);

    s_nxt.rdata = 16'h0000;
    if (rd_i)
    begin
      unique case (addr_i)
        `ADDR_CTRL: s_nxt.rdata = {12'h000, 1'b0, s_r.gie,
                                   s_r.prox_en, s_r.auto_en};
        `ADDR_SLEEP_TIME: s_nxt.rdata = {8'h00, s_r.sleep_time};
        `ADDR_WAKE_THR: s_nxt.rdata = s_r.wake_thr;
        `ADDR_BASE_MAVG: s_nxt.rdata = s_r.mavg;
        `ADDR_START_DLY: s_nxt.rdata = {8'h00, s_r.start_dly};
        `ADDR_PERIOD: s_nxt.rdata = {8'h00, s_r.period};
        `ADDR_KEY_EN: s_nxt.rdata = s_r.key_en;
        `ADDR_WAKE_EN: s_nxt.rdata = s_r.wake_en;
        `ADDR_STATE: s_nxt.rdata = {15'h0000, s_r.asleep};
        `ADDR_INT_STAT: s_nxt.rdata = {13'h0000, s_r.int_stat};
        `ADDR_INT_MASK: s_nxt.rdata = {13'h0000, s_r.int_mask};
        `ADDR_KEY_STAT_LO:
        begin
          s_nxt.rdata = {8'h00, key_touch_i[7:0]};
          s_nxt.rd_lo = 1'b1;
        end
        `ADDR_KEY_STAT_HI:
        begin
          s_nxt.rdata = {8'h00, key_touch_i[15:8]};
          s_nxt.rd_hi = 1'b1;
        end
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    if (both_read && !wake)
      s_nxt.wake_pend = 1'b0;
    // read flags live while a touch or a wake report is pending
    if (!touch_seen && !s_nxt.wake_pend)
    begin
      s_nxt.rd_lo = 1'b0;
      s_nxt.rd_hi = 1'b0;
    end
    s_nxt.irq_n = !(s_r.gie && ((touch_seen &&
                    !(s_nxt.rd_lo && s_nxt.rd_hi)) ||
                    s_nxt.wake_pend));
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.st <= ST_DELAY;
      s_r.sleep_time <= `RST_SLEEP_TIME;
      s_r.wake_thr <= `RST_WAKE_THR;
      s_r.mavg <= `RST_BASE_MAVG;
      s_r.start_dly <= `RST_START_DLY;
      s_r.period <= `RST_PERIOD;
      s_r.irq_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata_o = s_r.rdata;
  assign scan_start_o = s_r.scan_start;
  assign asleep_o = s_r.asleep;
  assign baseline_adj_o = s_r.base_adj;
  assign irq_o = s_r.irq;
  assign irq_out_n_o = s_r.irq_n;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_auto_sleep: assert property (normal && auto_if.expired && !held &&
    !wake |=> asleep_o) else $error("idle expiry missed");
  a_wake_cause: assert property ($fell(asleep_o) |-> $past(host_connect_i)
    || $past(s_r.prox_en && prox_detect_i) || $past(s_r.hit || hit_now))
    else $error("wake without cause");
  a_one_scan: assert property (s_r.st == ST_WSCAN && scan_done_i && !wake
    |=> s_r.st == ST_SLEEP ##1 asleep_o)
    else $error("wake scan did not return to sleep");
  a_prox_wake: assert property (s_r.st == ST_SLEEP && s_r.prox_en &&
    prox_detect_i |=> !asleep_o) else $error("proximity ignored");
  a_irq_gate: assert property (!irq_out_n_o |-> $past(s_r.gie))
    else $error("irq without global enable");
  a_base_sleep: assert property (normal && s_r.auto_en && !held &&
    baseline_i > s_r.mavg |=> asleep_o)
    else $error("baseline sleep missed");
  a_start_delay: assert property (scan_start_o |-> $past(s_r.dly_cnt) ==
    $past(dly_limit)) else $error("start delay wrong");
  a_period_adj: assert property (per_if.expired |=> baseline_adj_o ##1
    !baseline_adj_o) else $error("baseline adjust missing");
  a_force_sleep: assert property (wr_i && addr_i == `ADDR_CTRL &&
    wdata_i[`CTRL_FORCE] && normal && !wake |=> ##1 asleep_o)
    else $error("force sleep ignored");
  a_host_wake: assert property (asleep_o && s_r.st != ST_DELAY &&
    host_connect_i |=> !asleep_o) else $error("host wake failed");
  a_key_held: assert property (!asleep_o && held && !s_r.force_sl |=>
    !asleep_o) else $error("slept with key held");
  a_irq_touch: assert property (s_r.gie && touch_seen && !s_r.rd_lo &&
    !s_r.rd_hi && !rd_i |=> !irq_out_n_o)
    else $error("touch irq missing");
  a_timer_rst: assert property (touch_seen |=> !auto_if.expired)
    else $error("idle timer not restarted");

  c_enter_sleep: cover property ($rose(asleep_o));
  c_key_wake: cover property (s_r.st == ST_WSCAN && wake);
  c_prox_wake: cover property (s_r.st == ST_SLEEP && wake &&
    prox_detect_i);
  c_irq_release: cover property ($rose(irq_out_n_o) && touch_seen);
endmodule // touch_sleep_wake_control
`default_nettype wire
